// ==== amr_device.sv ====
// device end: mask registers for comm/logic, misc and vendor groups plus alert gating
// assumes one clock, synchronous active-low reset, status inputs synchronous to clk
// assumes the host waits for each answer before it sends the next request
// stored masks arrive as plain levels and are copied in, not followed continuously
`timescale 1ns/1ps
`include "amr_params.svh"
module amr_device
  import amr_pkg::*;
(
  input wire logic clk, // 50 mhz clock
  input wire logic resetn, // synchronous reset, active low
  amr_link_if.dev link, // command link from host
  input wire logic [7:0] comm_logic_status, // comm/logic status flags
  input wire logic first_alerter_status, // informational first-to-alert flag
  input wire logic [7:0] vendor_status, // vendor status flags
  input wire logic [7:0] nvm_comm_mask, // stored comm mask loaded at reset release
  input wire logic [7:0] nvm_vendor_mask, // stored vendor mask loaded at reset release
  input wire logic nvm_load, // pulse: reload masks from storage
  output logic alert_n, // alert line, active low
  output logic [7:0] comm_mask_out, // current comm/logic mask
  output logic [7:0] vendor_mask_out // current vendor mask
);
  // writable positions of the comm and vendor groups; their read-only positions always read zero
  localparam logic [7:0] COMM_WMASK = `AMR_COMM_WMASK;
  localparam logic [7:0] VEND_WMASK = `AMR_VEND_WMASK;

  // mask state; the misc group needs no storage, it is a constant
  logic [7:0] alert_mask_comm_logic_ff, nxt_alert_mask_comm_logic;
  logic [7:0] alert_mask_vendor_group_ff, nxt_alert_mask_vendor_group;
  logic [7:0] alert_mask_misc_group;
  logic loaded_ff, nxt_loaded; // low until storage has been copied in

  // link answer state
  logic ack_ff, nxt_ack;
  logic nak_ff, nxt_nak;
  logic [7:0] rdata_ff, nxt_rdata;

  // request decode
  logic load_now, take_req, is_write;
  logic cmd_ok, hit_comm, hit_misc, hit_vend, hit_any;
  logic wr_comm, wr_vend, rd_comm, rd_misc, rd_vend;

  // alert sources left after masking, one bit per status position
  logic [7:0] comm_src, vend_src;
  logic misc_src, any_src;
  logic alert_n_ff, nxt_alert_n;

  // misc group is a constant: the first-alerter source stays masked
  assign alert_mask_misc_group = `AMR_MISC_VALUE;

  // storage copy lands on the first edge after reset, or on request;
  // a request on such an edge is dropped with no answer, so the host
  // must not start before the second edge after reset release
  assign load_now = !loaded_ff || nvm_load;
  assign take_req = link.req && !load_now;
  assign is_write = (link.op == AMR_OP_WRITE);

  // selector decode; only the comm group checks the phase selection
  always_comb begin
    cmd_ok = take_req && (link.cmd == `AMR_CMD_MASK);
    hit_comm = cmd_ok && (link.sel == `AMR_SEL_COMM) && (link.phase == `AMR_PHASE_ALL);
    hit_misc = cmd_ok && (link.sel == `AMR_SEL_MISC);
    hit_vend = cmd_ok && (link.sel == `AMR_SEL_VEND);
    // a request that no group claims is still answered, with nak raised
    hit_any = hit_comm || hit_misc || hit_vend;
  end

  // access strobes; any operation other than a write word is a read
  always_comb begin
    wr_comm = hit_comm && is_write;
    wr_vend = hit_vend && is_write;
    rd_comm = hit_comm && !is_write;
    rd_misc = hit_misc && !is_write;
    rd_vend = hit_vend && !is_write;
  end

  // storage-loaded flag: cleared by reset, set on the first edge after it
  always_comb begin
    nxt_loaded = 1'b1;
  end

  // loaded flag register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      loaded_ff <= 1'b0;
    end else begin
      loaded_ff <= nxt_loaded;
    end
  end

  // mask registers: a storage load wins over a host write in the same cycle
  always_comb begin
    nxt_alert_mask_comm_logic = alert_mask_comm_logic_ff;
    nxt_alert_mask_vendor_group = alert_mask_vendor_group_ff;
    // the storage copy is cut to the writable positions as well
    if (load_now) begin
      nxt_alert_mask_comm_logic = nvm_comm_mask & COMM_WMASK;
      nxt_alert_mask_vendor_group = nvm_vendor_mask & VEND_WMASK;
    end else begin
      // read-only positions are cut here, so a write can never set them
      if (wr_comm) begin
        nxt_alert_mask_comm_logic = link.wdata & COMM_WMASK;
      end
      if (wr_vend) begin
        nxt_alert_mask_vendor_group = link.wdata & VEND_WMASK;
      end
    end
  end

  // reset values keep every source masked until storage has loaded
  always_ff @(posedge clk) begin
    if (!resetn) begin
      alert_mask_comm_logic_ff <= `AMR_COMM_RESET;
      alert_mask_vendor_group_ff <= `AMR_VEND_RESET;
    end else begin
      alert_mask_comm_logic_ff <= nxt_alert_mask_comm_logic;
      alert_mask_vendor_group_ff <= nxt_alert_mask_vendor_group;
    end
  end

  // answer strobes: every taken request is acked one cycle later; a write
  // to the read-only misc group is acked without refusal and changes nothing
  always_comb begin
    nxt_ack = take_req;
    nxt_nak = take_req && !hit_any; // wrong command, selector or phase
  end

  // strobes last exactly one cycle, which the host relies on
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ack_ff <= 1'b0;
      nak_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
      nak_ff <= nxt_nak;
    end
  end

  // read data: held until the next good read, untouched by refused ones
  always_comb begin
    nxt_rdata = rdata_ff;
    if (rd_comm) begin
      nxt_rdata = alert_mask_comm_logic_ff;
    end else if (rd_misc) begin
      nxt_rdata = alert_mask_misc_group;
    end else if (rd_vend) begin
      nxt_rdata = alert_mask_vendor_group_ff;
    end
  end

  // read data register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_ff <= `AMR_RDATA_RESET;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // per-bit gating: a source counts only where its mask bit is 0 and the
  // position is writable, so a stray read-only status bit never alerts
  genvar gi;
  generate
    for (gi = 0; gi < $bits(comm_src); gi = gi + 1) begin : g_src
      assign comm_src[gi] = comm_logic_status[gi] & ~alert_mask_comm_logic_ff[gi] & COMM_WMASK[gi];
      assign vend_src[gi] = vendor_status[gi] & ~alert_mask_vendor_group_ff[gi] & VEND_WMASK[gi];
    end
  endgenerate

  // first-alerter flag is informational only; its mask bit is fixed at 1
  assign misc_src = first_alerter_status & ~alert_mask_misc_group[`AMR_FIRST_ALERT_BIT];

  // any unmasked source pulls the line; a mask change reaches the pin one cycle later
  assign any_src = (|comm_src) || (|vend_src) || misc_src;

  // alert is registered so the pin never glitches while status inputs
  // settle; the price is one cycle of latency after any change
  always_comb begin
    nxt_alert_n = !any_src;
  end

  // alert register; idles high (released) through reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      alert_n_ff <= 1'b1;
    end else begin
      alert_n_ff <= nxt_alert_n;
    end
  end

  // every output comes straight from a flop
  assign link.ack = ack_ff;
  assign link.nak = nak_ff;
  assign link.rdata = rdata_ff;
  assign alert_n = alert_n_ff;
  assign comm_mask_out = alert_mask_comm_logic_ff;
  assign vendor_mask_out = alert_mask_vendor_group_ff;
endmodule

// ==== amr_params.svh ====
// constants for the alert mask register bank: command codes, selectors, bit layouts
// assumes inclusion by the package and both ends of the link
`ifndef AMR_PARAMS_SVH
`define AMR_PARAMS_SVH
`define AMR_CMD_MASK 8'h1b
`define AMR_SEL_COMM 8'h7e
`define AMR_SEL_MISC 8'h7f
`define AMR_SEL_VEND 8'h80
`define AMR_PHASE_ALL 8'hff
`define AMR_COMM_WMASK 8'hfa
`define AMR_MISC_VALUE 8'h01
`define AMR_VEND_WMASK 8'hce
`define AMR_COMM_RESET 8'hfa
`define AMR_VEND_RESET 8'hce
`define AMR_SELF_BIT 6
`define AMR_SYNC_BIT 1
`define AMR_FIRST_ALERT_BIT 0
`define AMR_RDATA_RESET 8'h00
`endif

// ==== amr_pkg.sv ====
// types shared by both ends of the alert mask command link
// assumes amr_params.svh holds all numeric constants
`include "amr_params.svh"
package amr_pkg;
  typedef enum logic [1:0] {
    AMR_OP_NONE = 2'h0,
    AMR_OP_WRITE = 2'h1,
    AMR_OP_READ = 2'h3
  } amr_op_t;
endpackage

// ==== amr_link_if.sv ====
// link carrying one decoded mask command between host controller and device
// assumes a single clock shared by both ends
`timescale 1ns/1ps
interface amr_link_if;
  import amr_pkg::*;
  logic req; // host request strobe, one cycle
  amr_op_t op; // write word or process-call read
  logic [7:0] cmd; // command code
  logic [7:0] sel; // mask selector byte
  logic [7:0] phase; // current phase selection
  logic [7:0] wdata; // write data
  logic ack; // device answer strobe, one cycle
  logic nak; // request refused
  logic [7:0] rdata; // read data
  modport dev (input req, op, cmd, sel, phase, wdata, output ack, nak, rdata);
  modport host (output req, op, cmd, sel, phase, wdata, input ack, nak, rdata);
endinterface

// ==== amr_host.sv ====
// host end: issues one mask write or read per user request over the command link
// assumes one clock shared with the device end
`timescale 1ns/1ps
`include "amr_params.svh"
module amr_host
  import amr_pkg::*;
(
  input wire logic clk, // 50 mhz clock
  input wire logic resetn, // synchronous reset, active low
  amr_link_if.host link, // command link to device
  input wire logic start, // pulse: begin a transfer
  input wire logic write, // 1 write word, 0 process-call read
  input wire logic [7:0] sel, // mask selector byte
  input wire logic [7:0] wdata, // data to write
  input wire logic keep_safe_bits, // force self-reset and sync-fault masks set
  output logic busy, // transfer in flight
  output logic done, // pulse: answer received
  output logic err, // refused, valid with done
  output logic [7:0] rdata // data read back
);
  typedef enum logic [1:0] {AMR_H_IDLE = 2'b00, AMR_H_REQ = 2'b01, AMR_H_WAIT = 2'b11} amr_hstate_t;
  amr_hstate_t state_ff, nxt_state;
  logic req_ff, nxt_req, busy_ff, nxt_busy, done_ff, nxt_done, err_ff, nxt_err;
  amr_op_t op_ff, nxt_op;
  logic [7:0] sel_ff, nxt_sel, wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;

  // one request at a time; the device answers one cycle after the strobe
  always_comb begin
    nxt_state = state_ff;
    nxt_req = 1'b0;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    nxt_err = err_ff;
    nxt_op = op_ff;
    nxt_sel = sel_ff;
    nxt_wdata = wdata_ff;
    nxt_rdata = rdata_ff;
    case (state_ff)
      AMR_H_IDLE: begin
        if (start) begin
          nxt_state = AMR_H_REQ;
          nxt_req = 1'b1;
          nxt_busy = 1'b1;
          nxt_op = write ? AMR_OP_WRITE : AMR_OP_READ;
          nxt_sel = sel;
          nxt_wdata = wdata;
          // the vendor group start-up hazards are avoided by keeping these set
          if (keep_safe_bits && sel == `AMR_SEL_VEND) begin
            nxt_wdata[`AMR_SELF_BIT] = 1'b1;
            nxt_wdata[`AMR_SYNC_BIT] = 1'b1;
          end
        end
      end
      AMR_H_REQ: nxt_state = AMR_H_WAIT;
      AMR_H_WAIT: begin
        if (link.ack) begin
          nxt_state = AMR_H_IDLE;
          nxt_busy = 1'b0;
          nxt_done = 1'b1;
          nxt_err = link.nak;
          if (op_ff == AMR_OP_READ) begin
            nxt_rdata = link.rdata;
          end
        end
      end
      default: nxt_state = AMR_H_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ff <= AMR_H_IDLE;
      req_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      err_ff <= 1'b0;
      op_ff <= AMR_OP_NONE;
      sel_ff <= 8'h00;
      wdata_ff <= 8'h00;
      rdata_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      req_ff <= nxt_req;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      err_ff <= nxt_err;
      op_ff <= nxt_op;
      sel_ff <= nxt_sel;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
    end
  end

  assign link.req = req_ff;
  assign link.op = op_ff;
  assign link.cmd = `AMR_CMD_MASK;
  assign link.sel = sel_ff;
  assign link.phase = `AMR_PHASE_ALL;
  assign link.wdata = wdata_ff;
  assign busy = busy_ff;
  assign done = done_ff;
  assign err = err_ff;
  assign rdata = rdata_ff;
endmodule

// ==== amr_link_asserts.sv ====
// checker for the mask command link between the host and device ends
// assumes signals taken straight from amr_link_if, one clock domain
`timescale 1ns/1ps
`include "amr_params.svh"
module amr_link_asserts
  import amr_pkg::*;
(
  input wire logic clk, // link clock
  input wire logic resetn, // sync reset, active low
  input wire logic req, // host strobe
  input wire amr_op_t op, // operation
  input wire logic [7:0] cmd, // command code
  input wire logic [7:0] sel, // selector
  input wire logic [7:0] phase, // phase selection
  input wire logic ack, // device answer
  input wire logic nak, // refusal
  input wire logic [7:0] rdata // read data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // the edge right after reset is skipped, requests there are ignored
  a_ack_after_req: assert property (req && $past(resetn) |=> ack) else $error("no ack");
  a_ack_single: assert property (ack |=> !ack) else $error("ack too long");
  a_nak_with_ack: assert property (nak |-> ack) else $error("nak alone");
  a_bad_sel_nak: assert property (req && $past(resetn) && (sel < 8'h7e || sel > 8'h80) |=> nak)
    else $error("bad selector accepted");
  a_comm_phase_ok: assert property (req && $past(resetn) && cmd == 8'h1b && sel == 8'h7e && phase == 8'hff
    |=> !nak) else $error("comm access refused");
  a_misc_reads_one: assert property (ack && !nak && $past(op) == AMR_OP_READ && $past(sel) == 8'h7f
    |-> rdata == 8'h01) else $error("misc read");
  a_comm_ro_zero: assert property (ack && !nak && $past(op) == AMR_OP_READ && $past(sel) == 8'h7e
    |-> (rdata & 8'h05) == 8'h00) else $error("comm ro bits");
  a_vend_ro_zero: assert property (ack && !nak && $past(op) == AMR_OP_READ && $past(sel) == 8'h80
    |-> (rdata & 8'h31) == 8'h00) else $error("vendor ro bits");
endmodule

// ==== alert_mask_registers_tb.sv ====
// testbench joining host and device ends of the mask link
// assumes both ends share clk; masks checked by readback and alert line
`timescale 1ns/1ps
module alert_mask_registers_tb
  import amr_pkg::*;
;
  logic clk = 0, resetn = 0, start = 0, write = 0, keep_safe_bits = 0, nvm_load = 0, first_alerter_status = 0;
  logic [7:0] sel = 0, wdata = 0, comm_logic_status = 0, vendor_status = 0;
  logic [7:0] nvm_comm_mask = 8'h00, nvm_vendor_mask = 8'hff;
  logic busy, done, err, alert_n;
  logic [7:0] rdata, comm_mask_out, vendor_mask_out;
  int n_errors = 0, tests_run = 0;
  always #10 clk = ~clk;
  amr_link_if lnk();
  amr_host u_amr_host(.clk, .resetn, .link(lnk.host), .start, .write, .sel, .wdata, .keep_safe_bits, .busy, .done,
    .err, .rdata);
  amr_device u_amr_device(.clk, .resetn, .link(lnk.dev), .comm_logic_status, .first_alerter_status,
    .vendor_status, .nvm_comm_mask, .nvm_vendor_mask, .nvm_load, .alert_n, .comm_mask_out, .vendor_mask_out);
  amr_link_asserts u_amr_link_asserts(.clk, .resetn, .req(lnk.req), .op(lnk.op), .cmd(lnk.cmd), .sel(lnk.sel),
    .phase(lnk.phase), .ack(lnk.ack), .nak(lnk.nak), .rdata(lnk.rdata));
  task report_and_stop();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  // one transfer; read data is compared only on reads
  task acc(input logic w, input logic [7:0] s, d, input logic e_err, input logic [7:0] e_rd);
    int i;
    @(negedge clk);
    write = w;
    sel = s;
    wdata = d;
    start = 1;
    @(negedge clk);
    start = 0;
    chk(busy === 1'b1, "busy while in flight");
    for (i = 0; i < 20 && done !== 1'b1; i++)
      @(negedge clk);
    chk(done === 1'b1 && busy === 1'b0 && err === e_err && (w || rdata === e_rd), "transfer result");
  endtask
  // status held two cycles so the registered alert has settled
  task alrt(input logic [7:0] c, v, input logic f, e);
    @(negedge clk);
    comm_logic_status = c;
    vendor_status = v;
    first_alerter_status = f;
    repeat (2) @(negedge clk);
    chk(alert_n === e, "alert level");
  endtask
  task t_masks();
    chk(comm_mask_out === 8'h00 && vendor_mask_out === 8'hce, "masks after load");
    acc(0, 8'h7e, 8'h00, 0, 8'h00);
    acc(0, 8'h80, 8'h00, 0, 8'hce);
    acc(1, 8'h7e, 8'hff, 0, 8'h00);
    acc(0, 8'h7e, 8'h00, 0, 8'hfa);
    acc(1, 8'h7e, 8'h05, 0, 8'h00);
    acc(0, 8'h7e, 8'h00, 0, 8'h00);
    acc(1, 8'h7f, 8'h00, 0, 8'h00);
    acc(0, 8'h7f, 8'h00, 0, 8'h01);
    acc(1, 8'h80, 8'hff, 0, 8'h00);
    acc(0, 8'h80, 8'h00, 0, 8'hce);
    $display("test masks ends");
  endtask
  task t_safe_bad();
    keep_safe_bits = 1;
    acc(1, 8'h80, 8'h00, 0, 8'h00);
    acc(0, 8'h80, 8'h00, 0, 8'h42);
    keep_safe_bits = 0;
    acc(1, 8'h80, 8'h31, 0, 8'h00);
    acc(0, 8'h80, 8'h00, 0, 8'h00);
    acc(0, 8'h81, 8'h00, 1, 8'h00);
    acc(1, 8'h7d, 8'h00, 1, 8'h00);
    $display("test safe and refused ends");
  endtask
  task t_alert();
    alrt(8'h80, 8'h00, 0, 0);
    alrt(8'h04, 8'h00, 0, 1);
    alrt(8'h00, 8'h00, 1, 1);
    alrt(8'h00, 8'h02, 0, 0);
    acc(1, 8'h7e, 8'h80, 0, 8'h00);
    alrt(8'h80, 8'h00, 0, 1);
    alrt(8'h00, 8'h00, 0, 1);
    $display("test alert ends");
  endtask
  // storage reload overrides host writes and is cut to writable bits
  task t_reload();
    nvm_comm_mask = 8'hff;
    nvm_vendor_mask = 8'h31;
    @(negedge clk);
    nvm_load = 1;
    @(negedge clk);
    nvm_load = 0;
    @(negedge clk);
    chk(comm_mask_out === 8'hfa && vendor_mask_out === 8'h00, "reload");
    alrt(8'h00, 8'h04, 0, 0);
    alrt(8'hff, 8'h00, 0, 1);
    $display("test reload ends");
  endtask
  initial begin
    repeat (8) @(negedge clk);
    resetn = 1;
    repeat (3) @(negedge clk);
    t_masks();
    t_safe_bad();
    t_alert();
    t_reload();
    report_and_stop();
  end
  // whole run is well under 500 cycles
  initial begin
    #100us;
    n_errors++;
    report_and_stop();
  end
endmodule
